// ### rtl/svtr_map.svh
// constants of the shadow vertical timing bank: indices, masks, resets
// assumes inclusion by bare name from the regfile and top design files
`ifndef SVTR_MAP_SVH
`define SVTR_MAP_SVH

// host i/o port addresses
`define SVTR_IO_INDEX_MONO 16'h03B4
`define SVTR_IO_DATA_MONO 16'h03B5
`define SVTR_IO_INDEX_COLOR 16'h03D4
`define SVTR_IO_DATA_COLOR 16'h03D5
`define SVTR_IO_MISC_OUT 16'h03C2

// dedicated shadow indices
`define SVTR_IDX_VBLANK_START 8'h46
`define SVTR_IDX_VBLANK_END 8'h47
`define SVTR_IDX_VRETRACE_START 8'h48
`define SVTR_IDX_VRETRACE_END 8'h49
`define SVTR_IDX_VOVERFLOW 8'h4A
`define SVTR_IDX_MAX_SCAN 8'h4B
`define SVTR_IDX_HDISP_END 8'h4C
`define SVTR_IDX_VDISP_END 8'h4D

// standard crt indices that feed shadows
`define SVTR_STD_HDISP_END 8'h01
`define SVTR_STD_OVERFLOW 8'h07
`define SVTR_STD_MAX_SCAN 8'h09
`define SVTR_STD_VRETRACE_START 8'h10
`define SVTR_STD_VRETRACE_END 8'h11
`define SVTR_STD_VDISP_END 8'h12
`define SVTR_STD_VBLANK_START 8'h15
`define SVTR_STD_VBLANK_END 8'h16

// writable bit masks (reserved bits clear)
`define SVTR_MASK_FULL 8'hFF
`define SVTR_MASK_VRETRACE_END 8'h0F
`define SVTR_MASK_VOVERFLOW 8'hEF
`define SVTR_MASK_MAX_SCAN 8'hE0
`define SVTR_MASK_SYNC_POL 8'hC0
`define SVTR_MASK_VBLANK_BIT9 8'h20
`define SVTR_MASK_VDE_BITS 8'h42

// field positions
`define SVTR_BIT_MISC_COLOR 0
`define SVTR_BIT_PANEL_LOCK 5

// reset value of every shadow
`define SVTR_RESET_VALUE 8'h00

`endif

// ### rtl/svtr_pkg.sv
// types shared by the shadow vertical timing bank
// assumes svtr_map.svh for numeric constants
package svtr_pkg;

  typedef logic [7:0] svtr_byte_t;
  typedef logic [2:0] svtr_slot_t;

  // source of a shadow update in the current cycle
  typedef enum logic [1:0] {
    SVTR_SRC_NONE,
    SVTR_SRC_DEDICATED,
    SVTR_SRC_STANDARD,
    SVTR_SRC_MISC
  } svtr_src_t;

endpackage

// ### rtl/svtr_mem_if.sv
// carrier between the bank controller and its shadow storage
// assumes a single clock domain on both sides
`timescale 1ns/100ps
interface svtr_mem_if;
  logic wr_en;
  svtr_pkg::svtr_slot_t wr_slot;
  svtr_pkg::svtr_byte_t wr_data;
  svtr_pkg::svtr_byte_t wr_mask;
  logic rd_en;
  svtr_pkg::svtr_slot_t rd_slot;
  svtr_pkg::svtr_byte_t rd_data;
  logic [63:0] contents;

  modport ctl (
    output wr_en, wr_slot, wr_data, wr_mask, rd_en, rd_slot,
    input rd_data, contents
  );
  modport mem (
    input wr_en, wr_slot, wr_data, wr_mask, rd_en, rd_slot,
    output rd_data, contents
  );
endinterface

// ### rtl/svtr_regfile.sv
// eight byte shadow storage with masked write and registered read
// assumes at most one write per cycle from the controller
`timescale 1ns/100ps
`include "svtr_map.svh"
module svtr_regfile (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // controller side
  svtr_mem_if.mem bus
);

  svtr_pkg::svtr_byte_t store [8];

  // bits outside the mask keep their value, so reserved stay zero
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 8; i++) begin
        store[i] <= `SVTR_RESET_VALUE;
      end
    end else if (bus.wr_en) begin
      store[bus.wr_slot] <= (store[bus.wr_slot] & ~bus.wr_mask) |
                            (bus.wr_data & bus.wr_mask);
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.rd_data <= `SVTR_RESET_VALUE;
    end else if (bus.rd_en) begin
      bus.rd_data <= store[bus.rd_slot];
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus.contents[i*8 +: 8] = store[i];
    end
  end

endmodule

// ### rtl/svtr_top.sv
// shadow vertical timing bank behind the crt controller data port
// assumes one host i/o access per pulse, synchronous to core_clk_i
//
// Contract
// [RULE1] Shadows are 8-bit read/write indices 46h-4Dh at the data port.
// [RULE2] Every shadow register clears to zero at reset.
// [RULE3] Index 46h holds vertical blank start bits 7:0.
// [RULE4] Index 47h holds vertical blank end bits 7:0.
// [RULE5] Index 48h holds vertical retrace start bits 7:0.
// [RULE6] Index 49h keeps retrace end bits 3:0; bits 7:4 reserved.
// [RULE7] Index 4Ah packs overflow bits 7,5,3,2,0; bit 4 reserved.
// [RULE8] Index 4Ah bit 6 mirrors standard index 7 bit 6.
// [RULE9] Index 4Ah bit 1 mirrors standard index 7 bit 1.
// [RULE10] Panel lock set: display-end overflow bits only through 4Ah.
// [RULE11] Index 4Bh: sync polarity copy 7:6, blank start bit 9 at 5.
// [RULE12] Index 4Ch mirrors index 01; panel lock limits writes to 4Ch.
// [RULE13] Index 4Dh mirrors index 12h; panel lock limits writes to 4Dh.
// [RULE14] CRT-only display: standard writes also update the shadow copy.
// [RULE15] Panel or TV selected: standard writes leave shadows untouched.
// [RULE16] Shadow contents are read only at their dedicated indices.
// [RULE17] Reserved shadow bits read zero and ignore writes.
`timescale 1ns/100ps
`include "svtr_map.svh"
module svtr_top (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // host i/o access
  input wire logic [15:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  output logic host_rdata_valid_o,
  // display selection and lock
  input wire logic crt_only_i,
  input wire logic [7:0] panel_lock_control_i,
  // shadow contents for the panel and tv timing
  output logic [63:0] shadow_regs_o
);

  svtr_mem_if mem_bus ();

  svtr_pkg::svtr_byte_t crtc_index;
  logic color_io;
  logic [15:0] index_port;
  logic [15:0] data_port;
  logic panel_lock;
  logic data_wr;
  logic data_rd;
  logic misc_wr;
  logic rd_pending;

  svtr_pkg::svtr_src_t next_src;
  logic next_wr_en;
  svtr_pkg::svtr_slot_t next_wr_slot;
  svtr_pkg::svtr_byte_t next_wr_mask;
  logic next_rd_en;
  svtr_pkg::svtr_slot_t next_rd_slot;

  // true for the eight dedicated indices
  function automatic logic is_shadow_index(input svtr_pkg::svtr_byte_t idx);
    return (idx >= `SVTR_IDX_VBLANK_START) && (idx <= `SVTR_IDX_VDISP_END);
  endfunction

  // slot number of a dedicated index
  function automatic svtr_pkg::svtr_slot_t slot_of(
    input svtr_pkg::svtr_byte_t idx
  );
    svtr_pkg::svtr_byte_t diff;
    diff = idx - `SVTR_IDX_VBLANK_START;
    return diff[2:0];
  endfunction

  // writable bits at a dedicated index
  function automatic svtr_pkg::svtr_byte_t own_mask(
    input svtr_pkg::svtr_byte_t idx
  );
    svtr_pkg::svtr_byte_t m;
    m = `SVTR_MASK_FULL;
    if (idx == `SVTR_IDX_VRETRACE_END) begin
      m = `SVTR_MASK_VRETRACE_END;
    end else if (idx == `SVTR_IDX_VOVERFLOW) begin
      m = `SVTR_MASK_VOVERFLOW;
    end else if (idx == `SVTR_IDX_MAX_SCAN) begin
      m = `SVTR_MASK_MAX_SCAN;
    end
    return m;
  endfunction

  // i/o base follows the colour select bit of the misc output write
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      color_io <= 1'b0;
    end else if (misc_wr) begin
      color_io <= host_wdata_i[`SVTR_BIT_MISC_COLOR];
    end
  end

  always_comb begin
    index_port = color_io ? `SVTR_IO_INDEX_COLOR : `SVTR_IO_INDEX_MONO;
    data_port = color_io ? `SVTR_IO_DATA_COLOR : `SVTR_IO_DATA_MONO;
    panel_lock = panel_lock_control_i[`SVTR_BIT_PANEL_LOCK];
    data_wr = host_wr_i && (host_addr_i == data_port);
    data_rd = host_rd_i && (host_addr_i == data_port);
    misc_wr = host_wr_i && (host_addr_i == `SVTR_IO_MISC_OUT);
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      crtc_index <= 8'h00;
    end else if (host_wr_i && (host_addr_i == index_port)) begin
      crtc_index <= host_wdata_i;
    end
  end

  // write routing: dedicated index, mirrored standard index, misc output
  always_comb begin
    next_src = svtr_pkg::SVTR_SRC_NONE;
    next_wr_slot = 3'h0;
    next_wr_mask = 8'h00;
    if (data_wr && is_shadow_index(crtc_index)) begin
      // [RULE1] dedicated index write
      next_src = svtr_pkg::SVTR_SRC_DEDICATED;
      next_wr_slot = slot_of(crtc_index);
      // [RULE17] reserved bits masked
      next_wr_mask = own_mask(crtc_index);
    end else if (data_wr && crt_only_i) begin
      // [RULE14] standard write mirrored
      next_src = svtr_pkg::SVTR_SRC_STANDARD;
      if (crtc_index == `SVTR_STD_VBLANK_START) begin
        // [RULE3] blank start low byte
        next_wr_slot = slot_of(`SVTR_IDX_VBLANK_START);
        next_wr_mask = `SVTR_MASK_FULL;
      end else if (crtc_index == `SVTR_STD_VBLANK_END) begin
        // [RULE4] blank end low byte
        next_wr_slot = slot_of(`SVTR_IDX_VBLANK_END);
        next_wr_mask = `SVTR_MASK_FULL;
      end else if (crtc_index == `SVTR_STD_VRETRACE_START) begin
        // [RULE5] retrace start low byte
        next_wr_slot = slot_of(`SVTR_IDX_VRETRACE_START);
        next_wr_mask = `SVTR_MASK_FULL;
      end else if (crtc_index == `SVTR_STD_VRETRACE_END) begin
        // [RULE6] retrace end nibble only
        next_wr_slot = slot_of(`SVTR_IDX_VRETRACE_END);
        next_wr_mask = `SVTR_MASK_VRETRACE_END;
      end else if (crtc_index == `SVTR_STD_OVERFLOW) begin
        // [RULE7] overflow bits same positions
        next_wr_slot = slot_of(`SVTR_IDX_VOVERFLOW);
        // [RULE8] [RULE9] display end bits follow
        // [RULE10] held off while panel locked
        next_wr_mask = panel_lock ?
          (`SVTR_MASK_VOVERFLOW & ~`SVTR_MASK_VDE_BITS) :
          `SVTR_MASK_VOVERFLOW;
      end else if (crtc_index == `SVTR_STD_MAX_SCAN) begin
        // [RULE11] blank start bit 9
        next_wr_slot = slot_of(`SVTR_IDX_MAX_SCAN);
        next_wr_mask = `SVTR_MASK_VBLANK_BIT9;
      end else if (crtc_index == `SVTR_STD_HDISP_END) begin
        // [RULE12] horizontal display end
        next_wr_slot = slot_of(`SVTR_IDX_HDISP_END);
        next_wr_mask = panel_lock ? 8'h00 : `SVTR_MASK_FULL;
      end else if (crtc_index == `SVTR_STD_VDISP_END) begin
        // [RULE13] vertical display end
        next_wr_slot = slot_of(`SVTR_IDX_VDISP_END);
        next_wr_mask = panel_lock ? 8'h00 : `SVTR_MASK_FULL;
      end else begin
        next_src = svtr_pkg::SVTR_SRC_NONE;
      end
    end else if (misc_wr && crt_only_i) begin
      // [RULE11] sync polarity copy
      next_src = svtr_pkg::SVTR_SRC_MISC;
      next_wr_slot = slot_of(`SVTR_IDX_MAX_SCAN);
      next_wr_mask = `SVTR_MASK_SYNC_POL;
    end
    // [RULE15] no crt-only means no mirroring
    next_wr_en = (next_src != svtr_pkg::SVTR_SRC_NONE) &&
                 (next_wr_mask != 8'h00);
  end

  always_comb begin
    mem_bus.wr_en = next_wr_en;
    mem_bus.wr_slot = next_wr_slot;
    mem_bus.wr_data = host_wdata_i;
    mem_bus.wr_mask = next_wr_mask;
    mem_bus.rd_en = next_rd_en;
    mem_bus.rd_slot = next_rd_slot;
  end

  // [RULE16] reads answered only at dedicated indices
  always_comb begin
    next_rd_en = data_rd && is_shadow_index(crtc_index);
    next_rd_slot = slot_of(crtc_index);
  end

  // two-stage read: storage register, then output register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_pending <= 1'b0;
      host_rdata_valid_o <= 1'b0;
    end else begin
      rd_pending <= next_rd_en;
      host_rdata_valid_o <= rd_pending;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_rdata_o <= 8'h00;
    end else if (rd_pending) begin
      host_rdata_o <= mem_bus.rd_data;
    end
  end

  // shadow copy for timing, one cycle behind storage is acceptable
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // [RULE2] zero after reset
      shadow_regs_o <= 64'h0000_0000_0000_0000;
    end else begin
      shadow_regs_o <= mem_bus.contents;
    end
  end

  svtr_regfile u_regfile (
    .core_clk_i (core_clk_i),
    .reset_n_i (reset_n_i),
    .bus (mem_bus.mem)
  );

endmodule

// ### test/svtr_checker.sv
// checker of the shadow bank, watching the top-level ports only
// assumes one-cycle strobes; i/o base tracked from misc output bit 0
`timescale 1ns/100ps
module svtr_checker (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // watched ports
  input wire logic [15:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic host_rdata_valid_o,
  input wire logic crt_only_i,
  input wire logic [7:0] panel_lock_control_i,
  input wire logic [63:0] shadow_regs_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] idx;
  logic col;
  logic [15:0] iport;
  logic [15:0] dport;
  logic dwr;
  logic drd;
  logic ded;
  assign iport = col ? 16'h03D4 : 16'h03B4;
  assign dport = col ? 16'h03D5 : 16'h03B5;
  assign dwr = host_wr_i && host_addr_i == dport;
  assign drd = host_rd_i && host_addr_i == dport;
  assign ded = idx >= 8'h46 && idx <= 8'h4D;
  // colour select from misc output bit 0, mono after reset
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      col <= 1'b0;
    end else if (host_wr_i && host_addr_i == 16'h03C2) begin
      col <= host_wdata_i[0];
    end
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx <= 8'h00;
    end else if (host_wr_i && host_addr_i == iport) begin
      idx <= host_wdata_i;
    end
  end
  a_rd_answer: assert property (
    drd && ded |-> ##2 host_rdata_valid_o)
    else $error("no read answer at a shadow index");
  a_rd_refused: assert property (
    drd && !ded |-> ##2 !host_rdata_valid_o)
    else $error("read answered at a non-shadow index");
  a_reset_clear: assert property (
    $rose(reset_n_i) |-> shadow_regs_o == 64'h0)
    else $error("shadows not clear after reset");
  a_vre_mask: assert property (dwr && idx == 8'h49 |-> ##2
    shadow_regs_o[31:24] == ($past(host_wdata_i, 2) & 8'h0F))
    else $error("retrace end shadow wrong");
  a_resv_zero: assert property (shadow_regs_o[31:28] == 4'h0 &&
    !shadow_regs_o[36] && shadow_regs_o[44:40] == 5'h00)
    else $error("reserved shadow bit set");
  a_std_locked: assert property (dwr && idx == 8'h15 && !crt_only_i
    |-> ##2 shadow_regs_o[7:0] == $past(shadow_regs_o[7:0], 2))
    else $error("locked standard write reached shadow");
  a_std_mirror: assert property (dwr && idx == 8'h16 && crt_only_i
    |-> ##2 shadow_regs_o[15:8] == $past(host_wdata_i, 2))
    else $error("standard write not mirrored");
  a_hde_lock: assert property (dwr && idx == 8'h01 && crt_only_i &&
    panel_lock_control_i[5] |-> ##2
    shadow_regs_o[55:48] == $past(shadow_regs_o[55:48], 2))
    else $error("panel lock let index 01 through");
endmodule
bind svtr_top svtr_checker chk (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .host_addr_i(host_addr_i), .host_wr_i(host_wr_i),
  .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i),
  .host_rdata_o(host_rdata_o), .host_rdata_valid_o(host_rdata_valid_o),
  .crt_only_i(crt_only_i), .panel_lock_control_i(panel_lock_control_i),
  .shadow_regs_o(shadow_regs_o));

// ### test/svtr_host.sv
// host model: indexed i/o accesses, one strobe pulse each
// assumes io() is called from the bench's main sequence
`timescale 1ns/100ps
module svtr_host (
  // clock
  input wire logic core_clk_i,
  // i/o strobes toward the bank
  output logic [15:0] host_addr_o,
  output logic host_wr_o,
  output logic host_rd_o,
  output logic [7:0] host_wdata_o
);
  initial begin
    host_addr_o = 16'h0000;
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    host_wdata_o = 8'h00;
  end
  task automatic io(input logic w, input logic [15:0] a,
                    input logic [7:0] d);
    @(negedge core_clk_i);
    host_addr_o = a;
    host_wr_o = w;
    host_rd_o = !w;
    host_wdata_o = d;
    @(negedge core_clk_i);
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    // released bus must not show a stale value
    host_addr_o = ~a;
    host_wdata_o = ~d;
  endtask
endmodule

// ### test/testbench.sv
// bench of the shadow bank: host model, queue of expected read data
// assumes one strobe per access; both i/o bases are exercised
`timescale 1ns/100ps
`define CHK(a, b) begin \
  n_checks++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("ERROR %0t got %h expected %h", $time, a, b); \
  end \
end
module testbench;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic crt_only_i = 1'b1;
  logic [7:0] lock = 8'h00;
  logic [15:0] base = 16'h03B4;
  logic [15:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic [63:0] shadows;
  int error_cnt = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'd19;
  logic [7:0] e;
  logic [7:0] d;
  logic [7:0] exp_v [8];
  logic [7:0] exp_q [$];
  logic [7:0] std_idx [8] = '{8'h15, 8'h16, 8'h10, 8'h11,
                              8'h07, 8'h09, 8'h01, 8'h12};
  always #12.5 core_clk_i = ~core_clk_i;
  svtr_host host (.core_clk_i(core_clk_i), .host_addr_o(addr),
    .host_wr_o(wr), .host_rd_o(rd), .host_wdata_o(wdata));
  svtr_top uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .host_addr_i(addr), .host_wr_i(wr), .host_rd_i(rd),
    .host_wdata_i(wdata), .host_rdata_o(rdata),
    .host_rdata_valid_o(rvalid), .crt_only_i(crt_only_i),
    .panel_lock_control_i(lock), .shadow_regs_o(shadows));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] msk(input int k);
    return k == 3 ? 8'h0F : k == 4 ? 8'hEF : k == 5 ? 8'hE0 : 8'hFF;
  endfunction
  task automatic acc(input logic [7:0] i, input logic w,
                     input logic [7:0] v);
    host.io(1'b1, base, i);
    host.io(w, base + 16'h0001, v);
  endtask
  task automatic read_all();
    for (int k = 0; k < 8; k++) begin
      exp_q.push_back(exp_v[k]);
      acc(8'h46 + 8'(k), 1'b0, 8'h00);
    end
  endtask
  // upd: shadows follow; lk: panel lock holds display-end paths
  task automatic std_pass(input logic upd, input logic lk);
    logic [7:0] m;
    for (int k = 0; k < 8; k++) begin
      d = rnd();
      m = (k == 5) ? 8'h20 : msk(k);
      if (lk && k == 4) m = m & 8'hBD;
      if ((lk && k > 5) || !upd) m = 8'h00;
      acc(std_idx[k], 1'b1, d);
      exp_v[k] = (exp_v[k] & ~m) | (d & m);
    end
    read_all();
  endtask
  task automatic summarize();
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("ERROR %0t reads left unanswered", $time);
    end
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // falling edge: answer settled, no race with its launch edge
  always @(negedge core_clk_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("ERROR %0t unexpected read answer", $time);
      end else begin
        e = exp_q.pop_front();
        `CHK(rdata, e)
      end
    end
  end
  initial begin
    #125000;
    error_cnt++;
    summarize();
  end
  initial begin
    for (int r = 0; r < 2; r++) begin
      reset_n_i = 1'b0;
      repeat (8) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      foreach (exp_v[k]) exp_v[k] = 8'h00;
      read_all();
      if (r == 1) break;
      for (int p = 0; p < 4; p++) begin
        for (int k = 0; k < 8; k++) begin
          d = (p == 0) ? 8'hFF : rnd();
          acc(8'h46 + 8'(k), 1'b1, d);
          exp_v[k] = d & msk(k);
        end
        read_all();
      end
      std_pass(1'b1, 1'b0);
      crt_only_i = 1'b0;
      std_pass(1'b0, 1'b0);
      crt_only_i = 1'b1;
      lock = rnd() | 8'h20;
      std_pass(1'b1, 1'b1);
      d = rnd();
      acc(8'h4A, 1'b1, d);
      exp_v[4] = d & 8'hEF;
      lock = rnd() & 8'hDF;
      for (int c = 0; c < 2; c++) begin
        crt_only_i = c[0];
        d = rnd() & 8'hFE;
        host.io(1'b1, 16'h03C2, d);
        if (c == 1) exp_v[5][7:6] = d[7:6];
        read_all();
      end
      // data port follows misc output bit 0
      d = rnd() | 8'h01;
      host.io(1'b1, 16'h03C2, d);
      exp_v[5][7:6] = d[7:6];
      base = 16'h03D4;
      read_all();
      // mono data port must stay silent on the colour base
      host.io(1'b0, 16'h03B5, 8'h00);
      d = rnd() & 8'hFE;
      host.io(1'b1, 16'h03C2, d);
      exp_v[5][7:6] = d[7:6];
      base = 16'h03B4;
      // standard and unmapped reads stay silent
      acc(8'h07, 1'b0, 8'h00);
      acc(8'h45, 1'b0, 8'h00);
      acc(8'h4E, 1'b0, 8'h00);
      for (int k = 0; k < 8; k++) begin
        `CHK(shadows[k*8+:8], exp_v[k])
      end
    end
    repeat (4) @(negedge core_clk_i);
    summarize();
  end
endmodule
